// *** include/prs_regs.vh ***
// Register map, field positions and timing constants of the rms block.
// Assumes inclusion by bare name from the design files.
`ifndef PRS_REGS_VH
`define PRS_REGS_VH

// Register offsets on the internal serial-port register bus
`define PRS_ADDR_APMODE      6'h0d
`define PRS_ADDR_APPARENT_POWER_MODE_REGISTER      6'h0e
`define PRS_ADDR_A_PGAIN     6'h10
`define PRS_ADDR_B_PGAIN     6'h11
`define PRS_ADDR_C_PGAIN     6'h12
`define PRS_ADDR_A_VOLTAGE_GAIN     6'h13
`define PRS_ADDR_B_VOLTAGE_GAIN     6'h14
`define PRS_ADDR_C_VOLTAGE_GAIN     6'h15
`define PRS_ADDR_A_CURRENT_RMS_OFFSET_VALUE    6'h16
`define PRS_ADDR_B_CURRENT_RMS_OFFSET_VALUE    6'h17
`define PRS_ADDR_C_CURRENT_RMS_OFFSET_VALUE    6'h18
`define PRS_ADDR_A_IRMS      6'h20
`define PRS_ADDR_B_IRMS      6'h21
`define PRS_ADDR_C_IRMS      6'h22
`define PRS_ADDR_A_VRMS      6'h23
`define PRS_ADDR_B_VRMS      6'h24
`define PRS_ADDR_C_VRMS      6'h25
`define PRS_ADDR_XTALK       6'h3d

// Accumulation mode field in both mode registers
`define PRS_MODE_HI          7
`define PRS_MODE_LO          6
`define PRS_MODE_ONE         2'h1
`define PRS_MODE_TWO         2'h2

// Reset values
`define PRS_RST_MODE         8'h00
`define PRS_RST_GAIN         12'h000
`define PRS_RST_OFS          12'h000
`define PRS_RST_XTALK        16'h0000
`define PRS_RST_RESULT       24'h000000

// Timing and arithmetic scaling
`define PRS_UPDATE_DIV       4'd12
`define PRS_SQRT_STEPS       4'd12
`define PRS_GAIN_UNITY       13'h1000
`define PRS_GAIN_SHIFT       12
`define PRS_OFS_SHIFT        15
`define PRS_LPF_SHIFT        10
`define PRS_VOLT_SHIFT       8

`endif

// *** design/prs_sqrt.v ***
// Iterative square root: 48-bit radicand to 24-bit root, two bits per clock.
// Assumes a start pulse no more often than once per twelve clocks.
`timescale 1ns/1ps
`include "prs_regs.vh"

module prs_sqrt
(
    input  wire        sys_clk_in,
    input  wire        arst_n_in,
    input  wire        start_in,
    input  wire [47:0] rad_in,
    output reg  [23:0] root_out,
    output reg         done_out
);

    reg  [27:0] rem_reg;
    reg  [23:0] root_reg;
    reg  [47:0] rad_reg;
    reg  [3:0]  cnt_reg;
    reg  [27:0] rem_src;
    reg  [23:0] root_src;
    reg  [47:0] rad_src;
    reg  [51:0] s1;
    reg  [51:0] s2;

    // One restoring step on one bit pair
    function [51:0] sq_step;
        input [27:0] rem;
        input [23:0] root;
        input [1:0]  pair;
        reg   [27:0] sh;
        reg   [27:0] tr;
        begin
            sh = {rem[25:0], pair};
            tr = {2'b00, root, 2'b01};
            if (sh >= tr)
                sq_step = {sh - tr, root[22:0], 1'b1};
            else
                sq_step = {sh, root[22:0], 1'b0};
        end
    endfunction

    always @*
    begin
        rem_src  = start_in ? 28'h0000000 : rem_reg;
        root_src = start_in ? 24'h000000 : root_reg;
        rad_src  = start_in ? rad_in : rad_reg;
        s1 = sq_step(rem_src, root_src, rad_src[47:46]);
        s2 = sq_step(s1[51:24], s1[23:0], rad_src[45:44]);
    end

    always @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rem_reg  <= 28'h0000000;
            root_reg <= 24'h000000;
            rad_reg  <= 48'h000000000000;
            cnt_reg  <= 4'h0;
            root_out <= `PRS_RST_RESULT;
            done_out <= 1'b0;
        end
        else
        begin
            rem_reg  <= s2[51:24];
            root_reg <= s2[23:0];
            rad_reg  <= {rad_src[43:0], 4'h0};
            done_out <= 1'b0;
            if (start_in)
                cnt_reg <= `PRS_SQRT_STEPS - 4'd1;
            else if (cnt_reg != 4'h0)
                cnt_reg <= cnt_reg - 4'd1;
            if (!start_in && cnt_reg == 4'd1)
            begin
                root_out <= s2[23:0];
                done_out <= 1'b1;
            end
        end
    end

endmodule // prs_sqrt

// *** design/prs_msq.v ***
// One channel: gain scaling, squaring, low-pass filter, offset on mean square.
// Assumes samples on the same clock, taken on each update tick.
`timescale 1ns/1ps
`include "prs_regs.vh"

module prs_msq
(
    input  wire        sys_clk_in,
    input  wire        arst_n_in,
    input  wire        tick_in,
    input  wire [23:0] samp_in,
    input  wire [11:0] gain_in,
    input  wire        samp_gain_en_in,
    input  wire        sq_gain_en_in,
    input  wire [11:0] ofs_in,
    output reg  [47:0] ms_out
);

    wire signed [13:0] gm      = $signed({1'b0, `PRS_GAIN_UNITY + {{1{gain_in[11]}}, gain_in}});
    wire signed [37:0] sprod   = $signed(samp_in) * gm;
    wire signed [25:0] ss      = samp_gain_en_in ? sprod[37:12] : {{2{samp_in[23]}}, samp_in};
    wire        [25:0] mag     = ss[25] ? (26'h0 - ss) : ss;
    wire        [51:0] sq      = mag * mag;
    wire        [64:0] qprod   = sq * gm[12:0];
    wire        [52:0] sqg     = sq_gain_en_in ? qprod[64:12] : {1'b0, sq};
    reg         [62:0] acc_reg;
    wire        [52:0] ms      = acc_reg[62:`PRS_LPF_SHIFT];
    wire signed [53:0] ofs_ext = {{27{ofs_in[11]}}, ofs_in, 15'h0000};
    wire signed [53:0] msc     = $signed({1'b0, ms}) + ofs_ext;

    always @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            acc_reg <= 63'h0;
            ms_out  <= 48'h000000000000;
        end
        else
        begin
            if (tick_in)
                acc_reg <= acc_reg - {10'h000, ms} + {10'h000, sqg};       // [R1]
            if (msc[53])
                ms_out <= 48'h000000000000;
            else if (msc[52:48] != 5'h00)
                ms_out <= 48'hffffffffffff;
            else
                ms_out <= msc[47:0];                                       // [R11]
        end
    end

endmodule // prs_msq

// *** design/prs_top.v ***
// Polyphase rms measurement: six channels, register file and result registers.
// Assumes current and voltage waveform samples arrive on sys_clk_in
// from on-chip logic; the serial port drives the register strobes.
//
// Notes on behaviour
// (R1) Rms is square, low-pass filter, then square root per channel.
// (R2) Six channels computed together, each result in its own register.
// (R3) Current rms uses the current waveform samples; power gain scales their square.
// (R4) Current rms is unsigned 24-bit, one LSB equals one sample LSB.
// (R5) Current and voltage results refresh at master clock over 12.
// (R6) Full-scale ac current settles near 1,898,124 decimal.
// (R7) Host writes only 01F7h to reserved 16-bit register 3Dh.
// (R8) Accumulation mode 1 or 2 scales current rms by sqrt(1+gain/4096).
// (R9) Host converts rms to units by per-phase constant, not gain.
// (R10) One 12-bit signed current rms offset per phase.
// (R11) Corrected rms is sqrt(rms squared plus offset times 32768).
// (R12) Host finds current offset from full-scale and full-scale/100 readings.
// (R13) Voltage rms uses voltage samples after voltage gain.
// (R14) Voltage gain scales voltage channel over plus or minus 50 percent.
// (R15) Voltage rms unsigned 24-bit, 256 LSBs per sample LSB.
// (R16) Full-scale ac voltage reads near 1C35C4h.
// (R17) Apparent mode 1 or 2 scales voltage rms by 1+gain/4096.
// (R18) Voltage gain 7FFh adds 50 percent, 800h removes 50 percent.
// (R19) Accumulation mode is bits 7 and 6 of the active power mode register.
// (R20) Results are read-only; reads return the last finished update.
`timescale 1ns/1ps
`include "prs_regs.vh"

module prs_top
(
    input  wire        sys_clk_in,
    input  wire        arst_n_in,
    input  wire [23:0] ia_samp_in,
    input  wire [23:0] ib_samp_in,
    input  wire [23:0] ic_samp_in,
    input  wire [15:0] va_samp_in,
    input  wire [15:0] vb_samp_in,
    input  wire [15:0] vc_samp_in,
    input  wire [5:0]  reg_addr_in,
    input  wire        reg_wr_in,
    input  wire [23:0] reg_wdata_in,
    input  wire        reg_rd_in,
    output reg  [23:0] reg_rdata_out,
    output reg         rms_update_out
);

    reg  [7:0]   active_power_mode_register;
    reg  [7:0]   apparent_power_mode_register;
    reg  [11:0]  phase_a_power_gain;
    reg  [11:0]  phase_b_power_gain;
    reg  [11:0]  phase_c_power_gain;
    reg  [11:0]  phase_a_voltage_gain;
    reg  [11:0]  phase_b_voltage_gain;
    reg  [11:0]  phase_c_voltage_gain;
    reg  [11:0]  phase_a_current_rms_offset;
    reg  [11:0]  phase_b_current_rms_offset;
    reg  [11:0]  phase_c_current_rms_offset;
    reg  [15:0]  crosstalk_trim_reserved;
    reg  [23:0]  phase_a_current_rms;
    reg  [23:0]  phase_b_current_rms;
    reg  [23:0]  phase_c_current_rms;
    reg  [23:0]  phase_a_voltage_rms;
    reg  [23:0]  phase_b_voltage_rms;
    reg  [23:0]  phase_c_voltage_rms;

    reg  [3:0]   div_reg;
    reg          tick_reg;
    reg  [23:0]  rdata_next;

    wire [1:0]   active_power_accumulation_mode;
    wire [1:0]   apparent_accumulation_mode;
    wire         cur_gain_en;
    wire         volt_gain_en;
    wire [143:0] samp_flat;
    wire [71:0]  gain_flat;
    wire [71:0]  ofs_flat;
    wire [287:0] ms_flat;
    wire [143:0] root_flat;
    wire [5:0]   done_vec;

    // Mode fields and gain enables
    assign active_power_accumulation_mode =
        active_power_mode_register[`PRS_MODE_HI:`PRS_MODE_LO];                  // [R19]
    assign apparent_accumulation_mode =
        apparent_power_mode_register[`PRS_MODE_HI:`PRS_MODE_LO];
    // Gains apply only in modes 1 and 2; modes 0 and 3 run at unity
    assign cur_gain_en  = (active_power_accumulation_mode == `PRS_MODE_ONE) ||
                          (active_power_accumulation_mode == `PRS_MODE_TWO);    // [R8]
    assign volt_gain_en = (apparent_accumulation_mode == `PRS_MODE_ONE) ||
                          (apparent_accumulation_mode == `PRS_MODE_TWO);        // [R17]

    // Channels 0..2 current, 3..5 voltage; voltage placed 8 bits up
    assign samp_flat = {
        {vc_samp_in, {`PRS_VOLT_SHIFT{1'b0}}},
        {vb_samp_in, {`PRS_VOLT_SHIFT{1'b0}}},
        {va_samp_in, {`PRS_VOLT_SHIFT{1'b0}}},                                 // [R15] [R16]
        ic_samp_in,
        ib_samp_in,
        ia_samp_in                                                             // [R3]
    };
    assign gain_flat = {
        phase_c_voltage_gain,
        phase_b_voltage_gain,
        phase_a_voltage_gain,
        phase_c_power_gain,
        phase_b_power_gain,
        phase_a_power_gain
    };
    // Voltage lanes carry no offset correction
    assign ofs_flat = {
        36'h000000000,
        phase_c_current_rms_offset,
        phase_b_current_rms_offset,
        phase_a_current_rms_offset                                             // [R10]
    };

    // Update tick at master clock over 12
    // First tick lands on the twelfth edge after reset
    always @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            div_reg  <= 4'h0;
            tick_reg <= 1'b0;
        end
        else
        begin
            if (div_reg == `PRS_UPDATE_DIV - 4'd1)
            begin
                div_reg  <= 4'h0;
                tick_reg <= 1'b1;                                              // [R5]
            end
            else
            begin
                div_reg  <= div_reg + 4'd1;
                tick_reg <= 1'b0;
            end
        end
    end

    // All six channels run side by side
    genvar ch;
    generate
        for (ch = 0; ch < 6; ch = ch + 1)
        begin : g_chan
            // Current lanes scale the square, voltage lanes the sample
            prs_msq u_msq
            (
                .sys_clk_in      (sys_clk_in),
                .arst_n_in       (arst_n_in),
                .tick_in         (tick_reg),
                .samp_in         (samp_flat[ch*24 +: 24]),
                .gain_in         (gain_flat[ch*12 +: 12]),
                .samp_gain_en_in ((ch >= 3) && volt_gain_en),                  // [R13] [R14]
                .sq_gain_en_in   ((ch < 3) && cur_gain_en),                    // [R8]
                .ofs_in          (ofs_flat[ch*12 +: 12]),
                .ms_out          (ms_flat[ch*48 +: 48])
            );
            prs_sqrt u_sqrt
            (
                .sys_clk_in (sys_clk_in),
                .arst_n_in  (arst_n_in),
                .start_in   (tick_reg),
                .rad_in     (ms_flat[ch*48 +: 48]),
                .root_out   (root_flat[ch*24 +: 24]),                          // [R1]
                .done_out   (done_vec[ch])
            );
        end
    endgenerate

    // Result registers load only on a finished root
    // All lanes share one tick, so lane 0 marks the update for all
    always @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            phase_a_current_rms <= `PRS_RST_RESULT;
            phase_b_current_rms <= `PRS_RST_RESULT;
            phase_c_current_rms <= `PRS_RST_RESULT;
            phase_a_voltage_rms <= `PRS_RST_RESULT;
            phase_b_voltage_rms <= `PRS_RST_RESULT;
            phase_c_voltage_rms <= `PRS_RST_RESULT;
            rms_update_out      <= 1'b0;
        end
        else
        begin
            rms_update_out <= done_vec[0];
            if (done_vec[0])
                phase_a_current_rms <= root_flat[23:0];                        // [R2] [R4] [R6]
            if (done_vec[1])
                phase_b_current_rms <= root_flat[47:24];
            if (done_vec[2])
                phase_c_current_rms <= root_flat[71:48];
            if (done_vec[3])
                phase_a_voltage_rms <= root_flat[95:72];                       // [R15]
            if (done_vec[4])
                phase_b_voltage_rms <= root_flat[119:96];
            if (done_vec[5])
                phase_c_voltage_rms <= root_flat[143:120];
        end
    end

    // Register writes; result addresses are read-only
    // Crosstalk trim is stored and read back only
    always @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            active_power_mode_register   <= `PRS_RST_MODE;
            apparent_power_mode_register <= `PRS_RST_MODE;
            phase_a_power_gain           <= `PRS_RST_GAIN;
            phase_b_power_gain           <= `PRS_RST_GAIN;
            phase_c_power_gain           <= `PRS_RST_GAIN;
            phase_a_voltage_gain         <= `PRS_RST_GAIN;
            phase_b_voltage_gain         <= `PRS_RST_GAIN;
            phase_c_voltage_gain         <= `PRS_RST_GAIN;
            phase_a_current_rms_offset   <= `PRS_RST_OFS;
            phase_b_current_rms_offset   <= `PRS_RST_OFS;
            phase_c_current_rms_offset   <= `PRS_RST_OFS;
            crosstalk_trim_reserved      <= `PRS_RST_XTALK;
        end
        else if (reg_wr_in)
        begin
            if (reg_addr_in == `PRS_ADDR_APMODE)
                active_power_mode_register <= reg_wdata_in[7:0];              // [R19]
            else if (reg_addr_in == `PRS_ADDR_APPARENT_POWER_MODE_REGISTER)
                apparent_power_mode_register <= reg_wdata_in[7:0];
            else if (reg_addr_in == `PRS_ADDR_A_PGAIN)
                phase_a_power_gain <= reg_wdata_in[11:0];
            else if (reg_addr_in == `PRS_ADDR_B_PGAIN)
                phase_b_power_gain <= reg_wdata_in[11:0];
            else if (reg_addr_in == `PRS_ADDR_C_PGAIN)
                phase_c_power_gain <= reg_wdata_in[11:0];
            else if (reg_addr_in == `PRS_ADDR_A_VOLTAGE_GAIN)
                phase_a_voltage_gain <= reg_wdata_in[11:0];                   // [R18]
            else if (reg_addr_in == `PRS_ADDR_B_VOLTAGE_GAIN)
                phase_b_voltage_gain <= reg_wdata_in[11:0];
            else if (reg_addr_in == `PRS_ADDR_C_VOLTAGE_GAIN)
                phase_c_voltage_gain <= reg_wdata_in[11:0];
            else if (reg_addr_in == `PRS_ADDR_A_CURRENT_RMS_OFFSET_VALUE)
                phase_a_current_rms_offset <= reg_wdata_in[11:0];             // [R10]
            else if (reg_addr_in == `PRS_ADDR_B_CURRENT_RMS_OFFSET_VALUE)
                phase_b_current_rms_offset <= reg_wdata_in[11:0];
            else if (reg_addr_in == `PRS_ADDR_C_CURRENT_RMS_OFFSET_VALUE)
                phase_c_current_rms_offset <= reg_wdata_in[11:0];
            else if (reg_addr_in == `PRS_ADDR_XTALK)
                crosstalk_trim_reserved <= reg_wdata_in[15:0];                // [R7]
        end
    end

    // Read decode; no read side effects on the running calculation
    always @*
    begin
        // Unmapped offsets read back as zero
        rdata_next = 24'h000000;
        if (reg_addr_in == `PRS_ADDR_APMODE)
            rdata_next = {16'h0000, active_power_mode_register};
        else if (reg_addr_in == `PRS_ADDR_APPARENT_POWER_MODE_REGISTER)
            rdata_next = {16'h0000, apparent_power_mode_register};
        else if (reg_addr_in == `PRS_ADDR_A_PGAIN)
            rdata_next = {12'h000, phase_a_power_gain};
        else if (reg_addr_in == `PRS_ADDR_B_PGAIN)
            rdata_next = {12'h000, phase_b_power_gain};
        else if (reg_addr_in == `PRS_ADDR_C_PGAIN)
            rdata_next = {12'h000, phase_c_power_gain};
        else if (reg_addr_in == `PRS_ADDR_A_VOLTAGE_GAIN)
            rdata_next = {12'h000, phase_a_voltage_gain};
        else if (reg_addr_in == `PRS_ADDR_B_VOLTAGE_GAIN)
            rdata_next = {12'h000, phase_b_voltage_gain};
        else if (reg_addr_in == `PRS_ADDR_C_VOLTAGE_GAIN)
            rdata_next = {12'h000, phase_c_voltage_gain};
        else if (reg_addr_in == `PRS_ADDR_A_CURRENT_RMS_OFFSET_VALUE)
            rdata_next = {12'h000, phase_a_current_rms_offset};
        else if (reg_addr_in == `PRS_ADDR_B_CURRENT_RMS_OFFSET_VALUE)
            rdata_next = {12'h000, phase_b_current_rms_offset};
        else if (reg_addr_in == `PRS_ADDR_C_CURRENT_RMS_OFFSET_VALUE)
            rdata_next = {12'h000, phase_c_current_rms_offset};
        else if (reg_addr_in == `PRS_ADDR_XTALK)
            rdata_next = {8'h00, crosstalk_trim_reserved};
        else if (reg_addr_in == `PRS_ADDR_A_IRMS)
            rdata_next = phase_a_current_rms;                                 // [R20]
        else if (reg_addr_in == `PRS_ADDR_B_IRMS)
            rdata_next = phase_b_current_rms;
        else if (reg_addr_in == `PRS_ADDR_C_IRMS)
            rdata_next = phase_c_current_rms;
        else if (reg_addr_in == `PRS_ADDR_A_VRMS)
            rdata_next = phase_a_voltage_rms;
        else if (reg_addr_in == `PRS_ADDR_B_VRMS)
            rdata_next = phase_b_voltage_rms;
        else if (reg_addr_in == `PRS_ADDR_C_VRMS)
            rdata_next = phase_c_voltage_rms;
    end

    always @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            reg_rdata_out <= 24'h000000;
        else if (reg_rd_in)
            reg_rdata_out <= rdata_next;                                       // [R20]
    end

endmodule // prs_top

// *** sim/prs_asserts.sv ***
// Checker for prs_top: register port timing and result update cadence.
// Assumes it is bound onto prs_top and sees only its ports.
`timescale 1ns/1ps

module prs_asserts
(
    input wire        sys_clk_in,
    input wire        arst_n_in,
    input wire [5:0]  reg_addr_in,
    input wire        reg_wr_in,
    input wire [23:0] reg_wdata_in,
    input wire        reg_rd_in,
    input wire [23:0] reg_rdata_out,
    input wire        rms_update_out
);
    reg  [11:0] wlow_reg;
    wire        res_rd  = reg_rd_in && reg_addr_in >= 6'h20 && reg_addr_in <= 6'h25;
    wire        gain_ad = reg_addr_in >= 6'h10 && reg_addr_in <= 6'h18;

    // Low bits of the write data bus one clock back, for readback comparison
    always @(posedge sys_clk_in or negedge arst_n_in)
        if (!arst_n_in)
            wlow_reg <= 12'h000;
        else
            wlow_reg <= reg_wdata_in[11:0];

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);

    a_update_next: assert property (rms_update_out |-> ##12 rms_update_out)
        else $error("update pulses not 12 clocks apart");
    a_update_gap: assert property (rms_update_out |=> !rms_update_out [*8])
        else $error("update pulse too soon");
    a_rdata_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
        else $error("read data moved without a read");
    a_result_stable: assert property (res_rd ##1 (reg_rd_in && $stable(reg_addr_in)
        && !rms_update_out) |=> $stable(reg_rdata_out))
        else $error("result changed between updates");
    a_unmapped_zero: assert property ((reg_rd_in && reg_addr_in >= 6'h26
        && reg_addr_in <= 6'h3c) |=> reg_rdata_out == 24'h000000)
        else $error("unmapped read not zero");
    a_gain_width: assert property ((reg_rd_in && gain_ad)
        |=> reg_rdata_out[23:12] == 12'h000)
        else $error("gain or offset upper bits not zero");
    a_mode_width: assert property ((reg_rd_in && (reg_addr_in == 6'h0d
        || reg_addr_in == 6'h0e)) |=> reg_rdata_out[23:8] == 16'h0000)
        else $error("mode register upper bits not zero");
    a_xtalk_width: assert property ((reg_rd_in && reg_addr_in == 6'h3d)
        |=> reg_rdata_out[23:16] == 8'h00)
        else $error("trim register upper bits not zero");
    a_write_back: assert property ((reg_wr_in && gain_ad) ##1 !reg_wr_in
        ##1 (reg_rd_in && !reg_wr_in && reg_addr_in == $past(reg_addr_in, 2))
        |=> reg_rdata_out[11:0] == $past(wlow_reg, 2))
        else $error("gain or offset readback wrong");
endmodule // prs_asserts

bind prs_top prs_asserts u_prs_asserts
(
    .sys_clk_in     (sys_clk_in),
    .arst_n_in      (arst_n_in),
    .reg_addr_in    (reg_addr_in),
    .reg_wr_in      (reg_wr_in),
    .reg_wdata_in   (reg_wdata_in),
    .reg_rd_in      (reg_rd_in),
    .reg_rdata_out  (reg_rdata_out),
    .rms_update_out (rms_update_out)
);

// *** sim/prs_host.sv ***
// Host model: drives the register strobes, one request per clock.
// Assumes the block answers a read one clock after the strobe edge.
`timescale 1ns/1ps

module prs_host
(
    input  wire        sys_clk_in,
    output reg  [5:0]  reg_addr_out,
    output reg         reg_wr_out,
    output reg  [23:0] reg_wdata_out,
    output reg         reg_rd_out,
    input  wire [23:0] reg_rdata_in
);
    initial
    begin
        reg_addr_out  = 6'h00;
        reg_wr_out    = 1'b0;
        reg_wdata_out = 24'h000000;
        reg_rd_out    = 1'b0;
    end

    task automatic wr_reg(input [5:0] a, input [23:0] d);
        begin
            @(posedge sys_clk_in);
            reg_addr_out  <= a;
            reg_wdata_out <= (a == 6'h3d) ? 24'h0001f7 : d;
            reg_wr_out    <= 1'b1;
            @(posedge sys_clk_in);
            reg_wr_out    <= 1'b0;
            reg_wdata_out <= ~reg_wdata_out;
        end
    endtask

    // Two back-to-back reads; unit scaling stays in host software
    task automatic rd2(input [5:0] a, output [23:0] d0, output [23:0] d1);
        begin
            @(posedge sys_clk_in);
            reg_addr_out <= a;
            reg_rd_out   <= 1'b1;
            @(posedge sys_clk_in);
            #1 d0 = reg_rdata_in;
            @(posedge sys_clk_in);
            reg_rd_out   <= 1'b0;
            #1 d1 = reg_rdata_in;
        end
    endtask
endmodule // prs_host

// *** sim/prs_top_tb.sv ***
// Testbench for prs_top: register access, update cadence, settled rms.
// Assumes prs_host drives the register port and prs_asserts is bound.
`timescale 1ns/1ps

module prs_top_tb;
    reg         clk          = 1'b0;
    reg         arst_n       = 1'b0;
    reg  [23:0] ia           = 24'h0;
    reg  [23:0] ib           = 24'h0;
    reg  [23:0] ic           = 24'h0;
    reg  [15:0] va           = 16'h0;
    reg  [15:0] vb           = 16'h0;
    reg  [15:0] vc           = 16'h0;
    reg  [15:0] seed         = 16'd53186;
    reg  [5:0]  rw_a [0:11]  = '{6'h0d, 6'h0e, 6'h10, 6'h11, 6'h12, 6'h13,
                                6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h3d};
    reg  [5:0]  cf_a [0:10]  = '{6'h0d, 6'h0e, 6'h10, 6'h11, 6'h12, 6'h13,
                                6'h14, 6'h15, 6'h16, 6'h17, 6'h18};
    reg  [23:0] cf_v [0:10]  = '{24'h40, 24'h80, 24'h0, 24'h7ff, 24'h0, 24'h0,
                                24'h7ff, 24'h800, 24'h0, 24'h0, 24'h7ff};
    reg  [23:0] exp_r [0:5];
    reg  [23:0] d0;
    reg  [23:0] d1;
    reg  [23:0] v;
    wire [5:0]  addr;
    wire        wr;
    wire        rd;
    wire [23:0] wdata;
    wire [23:0] rdata;
    wire        upd;
    int         num_errors   = 0;
    int         total_checks = 0;
    int         i;
    int         n;

    always #10 clk = ~clk;

    prs_host host (.sys_clk_in(clk), .reg_addr_out(addr), .reg_wr_out(wr),
                   .reg_wdata_out(wdata), .reg_rd_out(rd), .reg_rdata_in(rdata));

    prs_top dut (.sys_clk_in(clk), .arst_n_in(arst_n), .ia_samp_in(ia), .ib_samp_in(ib),
                 .ic_samp_in(ic), .va_samp_in(va), .vb_samp_in(vb), .vc_samp_in(vc),
                 .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata),
                 .reg_rd_in(rd), .reg_rdata_out(rdata), .rms_update_out(upd));

    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function [23:0] exp_rw(input [5:0] a, input [23:0] d);
        if (a == 6'h3d)
            exp_rw = 24'h0001f7;
        else if (a == 6'h0d || a == 6'h0e)
            exp_rw = {16'h0, d[7:0]};
        else
            exp_rw = {12'h0, d[11:0]};
    endfunction

    function [23:0] rms_exp(input real s, input real g, input real o);
        rms_exp = 24'($rtoi($sqrt(s * s * g + o * 32768.0)));
    endfunction

    task automatic check(input string name, input [23:0] seen, input [23:0] exp,
                         input [23:0] tol);
        reg [23:0] diff;
        begin
            total_checks++;
            diff = (seen > exp) ? seen - exp : exp - seen;
            if ((^seen === 1'bx) || diff > tol)
            begin
                num_errors++;
                $display("ERROR %s expected %0d seen %0d", name, exp, seen);
            end
        end
    endtask

    task automatic wait_upd(output int c);
        begin
            c = 0;
            @(posedge clk);
            while (upd !== 1'b1 && c < 100)
            begin
                @(posedge clk);
                c++;
            end
        end
    endtask

    task automatic finish_test;
        begin
            if (num_errors == 0 && total_checks > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask

    initial
    begin
        repeat (95000) @(posedge clk);
        num_errors++;
        finish_test;
    end

    initial
    begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        for (i = 0; i < 64; i++)
        begin
            host.rd2(i[5:0], d0, d1);
            check("reset value", d0, 24'h0, 24'h0);
        end
        // Writes to results and unmapped places must not stick
        for (i = 32; i <= 48; i++)
        begin
            seed = lfsr(seed);
            host.wr_reg(i[5:0], {seed[7:0], seed});
            host.rd2(i[5:0], d0, d1);
            check("read-only place", d0, 24'h0, 24'h0);
        end
        for (i = 0; i < 12; i++)
        begin
            seed = lfsr(seed);
            v = {seed[15:8], lfsr(seed)};
            host.wr_reg(rw_a[i], v);
            host.rd2(rw_a[i], d0, d1);
            check("rw register", d0, exp_rw(rw_a[i], v), 24'h0);
        end
        wait_upd(n);
        wait_upd(n);
        check("update spacing", 24'(n), 24'd11, 24'h0);
        for (i = 0; i < 11; i++)
            host.wr_reg(cf_a[i], cf_v[i]);
        ia <= 24'he30974;
        ib <= 24'd1000;
        ic <= 24'd1000;
        va <= 16'h1c35;
        vb <= 16'd1000;
        vc <= 16'hf830;
        exp_r[0] = rms_exp(-1898124.0, 1.0, 0.0);
        exp_r[1] = rms_exp(1000.0, 6143.0 / 4096.0, 0.0);
        exp_r[2] = rms_exp(1000.0, 1.0, 2047.0);
        exp_r[3] = rms_exp(7221.0 * 256.0, 1.0, 0.0);
        exp_r[4] = rms_exp(1000.0 * 6143.0 / 4096.0 * 256.0, 1.0, 0.0);
        exp_r[5] = rms_exp(1000.0 * 256.0, 1.0, 0.0);
        repeat (6500) wait_upd(n);
        for (i = 0; i < 6; i++)
        begin
            host.rd2(6'h20 + i[5:0], d0, d1);
            v = (exp_r[i] >> 9) + 24'd8;
            if (i < 3)
                check("current rms", d0, exp_r[i], v);
            else
                check("voltage rms", d0, exp_r[i], v);
        end
        finish_test;
    end
endmodule // prs_top_tb
